// >>> core/vr_protect_pkg.sv
// Constants, register map and state codes for the regulator supervision block
package vr_protect_pkg;
	localparam int NRAIL      = 2;      // 0 = core rail, 1 = graphics_rail
	localparam int MV_W       = 12;     // Width of sensed voltages in mV
	localparam int REF_W      = 16;     // Width of reference in 50 uV steps
	localparam int PH_W       = 3;      // Width of a phase count
	localparam int FIELD_W    = 3;      // Width of a slew code

	// Register offsets
	localparam logic [7:0] ADDR_CURRENT_REPORT = 8'h15;
	localparam logic [7:0] ADDR_FAST_SLEW      = 8'h1C;
	localparam logic [7:0] ADDR_SLOW_SLEW      = 8'h2A;

	// Field layout of fast_slew_select
	localparam int FAST_CORE_LSB = 0;
	localparam int FAST_GFX_LSB  = 4;
	localparam logic [7:0] FAST_SLEW_RESET = 8'h22;  // Code 2 on both rails: 12 mV/us
	localparam logic [7:0] SLOW_SLEW_RESET = 8'h00;

	// Timing and slew scale
	localparam int CLK_PERIOD_NS     = 100;
	localparam int REF_LSB_UV        = 50;
	localparam int SLEW_BASE_UV_US   = 3000;   // 3 mV/us at code 0
	localparam int SLEW_STEP_UV_US   = 4500;   // 4.5 mV/us per code
	localparam logic [REF_W-1:0] SLEW_BASE_LSB =
		REF_W'(SLEW_BASE_UV_US * CLK_PERIOD_NS / 1000 / REF_LSB_UV);
	localparam logic [REF_W-1:0] SLEW_STEP_LSB =
		REF_W'(SLEW_STEP_UV_US * CLK_PERIOD_NS / 1000 / REF_LSB_UV);
	localparam int MV_TO_REF = 1000 / REF_LSB_UV;

	// Voltage codes
	localparam int VID_FIRST_MV = 250;
	localparam int VID_STEP_MV  = 5;
	localparam int BOOT_MV      = 1050;
	localparam logic [REF_W-1:0] BOOT_REF = REF_W'(BOOT_MV * MV_TO_REF);

	// Current protection thresholds
	localparam logic [MV_W-1:0] WARN_MV = MV_W'(1500);
	localparam int OCP_PCT     = 130;
	localparam int OCP_MV      = 1500 * OCP_PCT / 100;
	localparam int RATIO_DEN   = 12;
	localparam int OCP_DELAY_NS  = 10000;
	localparam int OCP_DELAY_CYC = (OCP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W         = 8;

	// Current report conversion
	localparam logic [MV_W-1:0] CURRENT_MONITOR_PIN_OFFSET_MV = MV_W'(600);
	localparam logic [MV_W-1:0] CURRENT_MONITOR_PIN_SPAN_MV   = MV_W'(1500);
	localparam logic [7:0]      REPORT_MAX     = 8'hFF;

	// Rail sequencing states
	typedef enum logic [3:0] {
		RAIL_OFF  = 4'b0001,
		RAIL_SOFT = 4'b0010,
		RAIL_RUN  = 4'b0100,
		RAIL_SHUT = 4'b1000
	} rail_state_type;
endpackage

// >>> core/vr_current_protect_slew.sv
// Slew control, current warning, overcurrent latch and current report for two rails
`timescale 1ns/1ps
// Overview of operation
// - Driver enable output gates all external drivers
// - Non-zero boot soft start ramps at slow rate
// - Set-voltage command ramps reference at chosen rate
// - Slow rate register written by processor only
// - Unwritten slow rate equals half fast rate
// - Management bus sets per-rail fast rate
// - Fast rate 3 to 34.5, 4.5 per step
// - Fast rate resets to 12 mV/us
// - Sense above 1.5 V raises warning, alert low
// - Overcurrent trips after limit held for delay
// - Trip drops ready, tristates PWM on both rails
// - Trip on one rail shuts other rail
// - Fault cleared only by power-on or enable toggle
// - Phase count from power-state or auto setting
// - Overcurrent limit scaled by active phase ratio
// - Monitor voltage converted into rising report code
// - Monitor 600 mV reports code 00h
// - 2100 mV gives FFh, saturates above
// - Report never feeds warning or trip
module vr_current_protect_slew (
	input  wire logic                                  clk_sys,
	input  wire logic                                  nrst,
	input  wire logic                                  ce,
	input  wire logic                                  enable_pin,
	input  wire logic                                  vboot_strap,
	input  wire logic [vr_protect_pkg::PH_W-1:0]       hw_phase_strap [vr_protect_pkg::NRAIL],
	input  wire logic [vr_protect_pkg::MV_W-1:0]       summed_current_sense [vr_protect_pkg::NRAIL],
	input  wire logic [vr_protect_pkg::MV_W-1:0]       current_monitor_pin [vr_protect_pkg::NRAIL],
	input  wire logic                                  set_voltage_command,
	input  wire logic                                  svc_rail,
	input  wire logic [7:0]                            svc_vid,
	input  wire logic                                  svc_fast,
	input  wire logic                                  set_power_state_command,
	input  wire logic                                  sps_rail,
	input  wire logic [vr_protect_pkg::PH_W-1:0]       sps_phases,
	input  wire logic                                  proc_wr,
	input  wire logic                                  proc_rd,
	input  wire logic [7:0]                            proc_addr,
	input  wire logic [7:0]                            proc_wdata,
	input  wire logic                                  proc_rail,
	output logic      [7:0]                            proc_rdata,
	input  wire logic                                  mgmt_wr,
	input  wire logic                                  mgmt_rd,
	input  wire logic [7:0]                            mgmt_addr,
	input  wire logic [7:0]                            mgmt_wdata,
	output logic      [7:0]                            mgmt_rdata,
	input  wire logic                                  auto_phase_wr,
	input  wire logic                                  auto_rail,
	input  wire logic [vr_protect_pkg::PH_W-1:0]       auto_phases,
	output logic                                       driver_enable_out,
	output logic                                       regulator_ready,
	output logic                                       alert_n,
	output logic      [vr_protect_pkg::NRAIL-1:0]      max_current_warning,
	output logic      [vr_protect_pkg::NRAIL-1:0]      ocp_fault,
	output logic      [vr_protect_pkg::NRAIL-1:0]      pwm_hiz,
	output logic      [vr_protect_pkg::REF_W-1:0]      reference [vr_protect_pkg::NRAIL]
);

	localparam int NRAIL = vr_protect_pkg::NRAIL;
	localparam int MV_W  = vr_protect_pkg::MV_W;
	localparam int REF_W = vr_protect_pkg::REF_W;
	localparam int PH_W  = vr_protect_pkg::PH_W;
	localparam int DLY_W = vr_protect_pkg::DLY_W;
	localparam logic [DLY_W-1:0] DELAY_LAST = DLY_W'(vr_protect_pkg::OCP_DELAY_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Reference level for a voltage code, in 50 uV steps
	function automatic logic [REF_W-1:0] vid_to_ref(input logic [7:0] vid);
		int mv;
		mv = vr_protect_pkg::VID_FIRST_MV + vr_protect_pkg::VID_STEP_MV * (int'(vid) - 1);
		if (vid == 8'h00)
			return '0;
		return REF_W'(mv * vr_protect_pkg::MV_TO_REF);
	endfunction

	// Limit ratio numerator over twelfths, by hardware and active phases
	function automatic int ratio_num(input logic [PH_W-1:0] hw, input logic [PH_W-1:0] act);
		int num;
		num = vr_protect_pkg::RATIO_DEN;
		unique case ({hw, act})
			{3'd4, 3'd3}: num = 9;
			{3'd4, 3'd2}: num = 7;
			{3'd4, 3'd1}: num = 5;
			{3'd3, 3'd2}: num = 8;
			{3'd3, 3'd1}: num = 5;
			{3'd2, 3'd1}: num = 7;
			default:      num = vr_protect_pkg::RATIO_DEN;
		endcase
		return num;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	localparam int SYNC_W = 2 + NRAIL * (PH_W + 2 * MV_W);
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_meta;
	logic [SYNC_W-1:0] pins_sync;

	assign pins_raw = {enable_pin, vboot_strap,
		hw_phase_strap[1], hw_phase_strap[0],
		summed_current_sense[1], summed_current_sense[0],
		current_monitor_pin[1], current_monitor_pin[0]};

	// Two-flop capture, running through reset so straps have settled at release
	always_ff @(posedge clk_sys)
	begin
		if (ce)
		begin
			pins_meta <= pins_raw;
			pins_sync <= pins_meta;
		end
	end

	logic                  en_s;
	logic                  vboot_s;
	logic [PH_W-1:0]       hw_s    [NRAIL];
	logic [MV_W-1:0]       summed_current_sense_s  [NRAIL];
	logic [MV_W-1:0]       current_monitor_pin_s  [NRAIL];

	assign {en_s, vboot_s, hw_s[1], hw_s[0], summed_current_sense_s[1], summed_current_sense_s[0], current_monitor_pin_s[1], current_monitor_pin_s[0]} = pins_sync;

	////////////////////////////////////////////////////////////////////////////
	// Straps, enable edges and shared fault

	logic strap_taken;
	logic vboot_nonzero;
	logic en_prev;
	logic en_toggle;
	logic fault_any;

	assign en_toggle = en_s ^ en_prev;
	assign fault_any = |ocp_fault;

	// Boot strap caught once after reset release
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			strap_taken   <= 1'b0;
			vboot_nonzero <= 1'b0;
			en_prev       <= 1'b0;
		end
		else if (ce)
		begin
			en_prev <= en_s;
			if (!strap_taken)
			begin
				strap_taken   <= 1'b1;
				vboot_nonzero <= vboot_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slew registers

	logic [7:0] fast_slew_select;
	logic [7:0] slow_slew_select;
	logic       slow_written;
	wire        proc_wr_slow = proc_wr && proc_addr == vr_protect_pkg::ADDR_SLOW_SLEW;
	wire        mgmt_wr_fast = mgmt_wr && mgmt_addr == vr_protect_pkg::ADDR_FAST_SLEW;

	// Fast rate from management side, slow rate from processor side only
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			fast_slew_select <= vr_protect_pkg::FAST_SLEW_RESET;
			slow_slew_select <= vr_protect_pkg::SLOW_SLEW_RESET;
			slow_written     <= 1'b0;
		end
		else if (ce)
		begin
			if (mgmt_wr_fast)
				fast_slew_select <= mgmt_wdata;
			if (proc_wr_slow)
			begin
				slow_slew_select <= proc_wdata;
				slow_written     <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-rail logic

	logic [7:0]                      report       [NRAIL];
	logic [NRAIL-1:0]                warn_next;
	logic [NRAIL-1:0]                rail_run;

	generate
		for (genvar r = 0; r < NRAIL; r++)
		begin : g_rail
			localparam int FLSB = (r == 0) ? vr_protect_pkg::FAST_CORE_LSB : vr_protect_pkg::FAST_GFX_LSB;
			vr_protect_pkg::rail_state_type state;
			vr_protect_pkg::rail_state_type next_state;
			logic [REF_W-1:0] target;
			logic             use_fast;
			logic [PH_W-1:0]  hw_phases;
			logic [PH_W-1:0]  act_phases;
			logic [DLY_W-1:0] dly_cnt;
			// Rate steps per clock in 50 uV units
			wire [vr_protect_pkg::FIELD_W-1:0] fast_code = fast_slew_select[FLSB +: vr_protect_pkg::FIELD_W];
			wire [REF_W-1:0] fast_step = vr_protect_pkg::SLEW_BASE_LSB +
				REF_W'(vr_protect_pkg::SLEW_STEP_LSB * fast_code);
			wire [REF_W-1:0] slow_step = slow_written ?
				vr_protect_pkg::SLEW_BASE_LSB + REF_W'(vr_protect_pkg::SLEW_STEP_LSB * slow_slew_select[2:0])
				: (fast_step >> 1);
			wire [REF_W-1:0] step = (state == vr_protect_pkg::RAIL_RUN && use_fast) ? fast_step : slow_step;
			// Ramp toward target, never past it
			wire [REF_W:0]   up_sum   = {1'b0, reference[r]} + {1'b0, step};
			wire [REF_W-1:0] ramp_up  = (up_sum >= {1'b0, target}) ? target : up_sum[REF_W-1:0];
			wire [REF_W-1:0] ramp_dn  = (reference[r] - target <= step) ? target : reference[r] - step;
			wire [REF_W-1:0] next_ref = (reference[r] < target) ? ramp_up : ramp_dn;
			// Phase-scaled limit and comparators
			wire [23:0] limit_full = 24'(vr_protect_pkg::OCP_MV * ratio_num(hw_phases, act_phases)
				/ vr_protect_pkg::RATIO_DEN);
			wire        over_limit = {12'h000, summed_current_sense_s[r]} > limit_full;
			wire        over_warn  = summed_current_sense_s[r] > vr_protect_pkg::WARN_MV;
			wire        live       = state == vr_protect_pkg::RAIL_SOFT || state == vr_protect_pkg::RAIL_RUN;
			wire        trip       = live && over_limit && dly_cnt == DELAY_LAST;
			// Monitor voltage to 8-bit report
			wire [MV_W-1:0] current_monitor_pin_d   = current_monitor_pin_s[r] - vr_protect_pkg::CURRENT_MONITOR_PIN_OFFSET_MV;
			wire [19:0]     current_monitor_pin_mul = 20'(current_monitor_pin_d) * 20'(255);
			wire [7:0]      next_rep = (current_monitor_pin_s[r] <= vr_protect_pkg::CURRENT_MONITOR_PIN_OFFSET_MV) ? 8'h00 :
				(current_monitor_pin_d >= vr_protect_pkg::CURRENT_MONITOR_PIN_SPAN_MV) ? vr_protect_pkg::REPORT_MAX :
				8'(current_monitor_pin_mul / 20'(vr_protect_pkg::CURRENT_MONITOR_PIN_SPAN_MV));
			// Phase command from either bus, clamped to hardware count
			wire             ps_hit   = set_power_state_command && sps_rail == 1'(r);
			wire             ap_hit   = auto_phase_wr && auto_rail == 1'(r);
			wire [PH_W-1:0]  ph_req   = ps_hit ? sps_phases : auto_phases;
			wire [PH_W-1:0]  ph_clamp = (ph_req > hw_phases) ? hw_phases :
				(ph_req == '0) ? PH_W'(1) : ph_req;
			wire             svc_hit  = set_voltage_command && svc_rail == 1'(r);

			// Sequencing decision
			always_comb
			begin
				next_state = state;
				unique case (state)
					vr_protect_pkg::RAIL_OFF:
						if (en_s && strap_taken && !fault_any)
							next_state = vboot_nonzero ? vr_protect_pkg::RAIL_SOFT : vr_protect_pkg::RAIL_RUN;
					vr_protect_pkg::RAIL_SOFT:
						if (reference[r] == target)
							next_state = vr_protect_pkg::RAIL_RUN;
					vr_protect_pkg::RAIL_RUN:
						;
					vr_protect_pkg::RAIL_SHUT:
						if (!en_s)
							next_state = vr_protect_pkg::RAIL_OFF;
				endcase
				if (fault_any || trip)
					next_state = vr_protect_pkg::RAIL_SHUT;
				else if (!en_s)
					next_state = vr_protect_pkg::RAIL_OFF;
			end

			// State, target and reference
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
				begin
					state        <= vr_protect_pkg::RAIL_OFF;
					target       <= '0;
					use_fast     <= 1'b0;
					reference[r] <= '0;
				end
				else if (ce)
				begin
					state <= next_state;
					if (state == vr_protect_pkg::RAIL_OFF)
					begin
						target       <= vboot_nonzero ? vr_protect_pkg::BOOT_REF : '0;
						use_fast     <= 1'b0;
						reference[r] <= '0;
					end
					else if (state == vr_protect_pkg::RAIL_RUN && svc_hit)
					begin
						target   <= vid_to_ref(svc_vid);
						use_fast <= svc_fast;
					end
					if (live)
						reference[r] <= next_ref;
				end
			end

			// Phase counts
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
				begin
					hw_phases  <= PH_W'(1);
					act_phases <= PH_W'(1);
				end
				else if (ce)
				begin
					if (!strap_taken)
					begin
						hw_phases  <= hw_s[r];
						act_phases <= hw_s[r];
					end
					else if (ps_hit || ap_hit)
						act_phases <= ph_clamp;
				end
			end

			// Fault delay, latch, warning and report
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
				begin
					dly_cnt                <= '0;
					ocp_fault[r]           <= 1'b0;
					max_current_warning[r] <= 1'b0;
					report[r]              <= 8'h00;
				end
				else if (ce)
				begin
					dly_cnt                <= (live && over_limit && dly_cnt != DELAY_LAST) ? dly_cnt + 1'b1 : '0;
					ocp_fault[r]           <= trip | (ocp_fault[r] & ~en_toggle);
					max_current_warning[r] <= over_warn;
					report[r]              <= next_rep;
				end
			end

			assign rail_run[r] = state == vr_protect_pkg::RAIL_RUN;
			assign warn_next[r] = over_warn;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pin outputs and register reads

	wire next_drv   = en_s && strap_taken && !fault_any;
	wire next_ready = &rail_run && !fault_any;

	wire [7:0] proc_sel =
		(proc_addr == vr_protect_pkg::ADDR_CURRENT_REPORT) ? report[proc_rail] :
		(proc_addr == vr_protect_pkg::ADDR_SLOW_SLEW)      ? slow_slew_select : 8'h00;
	wire [7:0] mgmt_sel =
		(mgmt_addr == vr_protect_pkg::ADDR_FAST_SLEW)      ? fast_slew_select :
		(mgmt_addr == vr_protect_pkg::ADDR_SLOW_SLEW)      ? slow_slew_select : 8'h00;

	// Registered outputs
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			driver_enable_out <= 1'b0;
			regulator_ready   <= 1'b0;
			alert_n           <= 1'b1;
			pwm_hiz           <= '1;
			proc_rdata        <= 8'h00;
			mgmt_rdata        <= 8'h00;
		end
		else if (ce)
		begin
			driver_enable_out <= next_drv;
			regulator_ready   <= next_ready;
			alert_n           <= ~|warn_next;
			pwm_hiz           <= {NRAIL{fault_any || !en_s}} | ~{NRAIL{strap_taken}};
			if (proc_rd)
				proc_rdata <= proc_sel;
			if (mgmt_rd)
				mgmt_rdata <= mgmt_sel;
		end
	end

endmodule

// >>> test/vr_protect_assertions.sv
// Port-level checker for the regulator supervision block
`timescale 1ns/1ps
module vr_protect_assertions (
	input wire logic		clk_sys,
	input wire logic		nrst,
	input wire logic		enable_pin,
	input wire logic [11:0]	summed_current_sense [vr_protect_pkg::NRAIL],
	input wire logic [11:0]	current_monitor_pin [vr_protect_pkg::NRAIL],
	input wire logic		proc_rd,
	input wire logic [7:0]	proc_addr,
	input wire logic		proc_rail,
	input wire logic [7:0]	proc_rdata,
	input wire logic		mgmt_wr,
	input wire logic		mgmt_rd,
	input wire logic [7:0]	mgmt_addr,
	input wire logic [7:0]	mgmt_rdata,
	input wire logic		regulator_ready,
	input wire logic		alert_n,
	input wire logic [1:0]	max_current_warning,
	input wire logic [1:0]	ocp_fault,
	input wire logic [1:0]	pwm_hiz
);
	logic [2:0]	run_cnt;
	logic [2:0]	en_quiet;
	logic		en_q;
	logic [7:0]	hot_cnt;
	logic [7:0]	any_cnt;
	logic		fast_written;
	// Decoded views of the watched ports
	wire [11:0]	s0 = summed_current_sense[0];
	wire [11:0]	m0 = current_monitor_pin[0];
	wire		live = run_cnt == 3'h7;
	wire		over_w = s0 > vr_protect_pkg::WARN_MV;
	wire		m0_high = m0 >= 12'h834;
	wire		rd0 = live && proc_rd && !proc_rail && proc_addr == vr_protect_pkg::ADDR_CURRENT_REPORT;
	wire		rep_end = rd0 && (m0 <= vr_protect_pkg::CURRENT_MONITOR_PIN_OFFSET_MV || m0_high);
	wire		rd_fast = mgmt_rd && mgmt_addr == vr_protect_pkg::ADDR_FAST_SLEW;

	// Cycle counters behind the timing properties
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			run_cnt <= 3'h0;
			en_quiet <= 3'h0;
			en_q <= 1'b0;
			hot_cnt <= 8'h00;
			any_cnt <= 8'h00;
			fast_written <= 1'b0;
		end
		else
		begin
			run_cnt <= live ? run_cnt : run_cnt + 3'h1;
			en_q <= enable_pin;
			en_quiet <= (enable_pin != en_q) ? 3'h0 : en_quiet + {2'h0, en_quiet != 3'h7};
			hot_cnt <= (s0 > 12'h79E && regulator_ready) ? hot_cnt + {7'h00, hot_cnt != 8'hFF} : 8'h00;
			any_cnt <= (s0 > 12'h32C) ? any_cnt + {7'h00, any_cnt != 8'hFF} : 8'h00;
			fast_written <= fast_written || (mgmt_wr && mgmt_addr == vr_protect_pkg::ADDR_FAST_SLEW);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence s_shut;
		pwm_hiz == 2'b11 && !regulator_ready;
	endsequence
	sequence s_mon_still;
		$stable(m0) [*6];
	endsequence

	property p_alert;
		live |-> alert_n == !(|max_current_warning);
	endproperty
	property p_warn;
		live && $past(over_w, 2) == $past(over_w, 4) && $past(over_w, 3) == $past(over_w, 4)
			|-> max_current_warning[0] == $past(over_w, 3);
	endproperty
	property p_trip;
		hot_cnt == 8'h64 |-> ##[0:8] ocp_fault[0];
	endproperty
	property p_early;
		$rose(ocp_fault[0]) && !ocp_fault[1] |-> any_cnt >= 8'h5F;
	endproperty
	property p_shut;
		$rose(ocp_fault[0]) |=> s_shut;
	endproperty
	property p_latch;
		ocp_fault[0] && en_quiet == 3'h7 |=> ocp_fault[0];
	endproperty
	property p_report;
		s_mon_still ##0 rep_end |=> proc_rdata == ($past(m0_high) ? 8'hFF : 8'h00);
	endproperty
	property p_fast_rst;
		!fast_written && rd_fast |=> mgmt_rdata == vr_protect_pkg::FAST_SLEW_RESET;
	endproperty

	a_alert: assert property (p_alert)
		else $error("alert line disagrees with warnings");
	a_warn: assert property (p_warn)
		else $error("warning does not follow sense level");
	a_trip: assert property (p_trip)
		else $error("overcurrent did not trip in time");
	a_early: assert property (p_early)
		else $error("overcurrent tripped too early");
	a_shut: assert property (p_shut)
		else $error("trip did not shut both rails");
	a_latch: assert property (p_latch)
		else $error("fault cleared without enable toggle");
	a_report: assert property (p_report)
		else $error("current report end value wrong");
	a_fast_rst: assert property (p_fast_rst)
		else $error("fast slew reset value wrong");
endmodule

bind vr_current_protect_slew vr_protect_assertions vr_protect_assertions_inst (
	.clk_sys(clk_sys), .nrst(nrst), .enable_pin(enable_pin), .summed_current_sense(summed_current_sense),
	.current_monitor_pin(current_monitor_pin), .proc_rd(proc_rd), .proc_addr(proc_addr),
	.proc_rail(proc_rail), .proc_rdata(proc_rdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
	.mgmt_addr(mgmt_addr), .mgmt_rdata(mgmt_rdata), .regulator_ready(regulator_ready),
	.alert_n(alert_n), .max_current_warning(max_current_warning), .ocp_fault(ocp_fault),
	.pwm_hiz(pwm_hiz)
);

// >>> test/driver_stage_model.sv
// Behavioural external driver stage fed by the enable and tristate outputs
`timescale 1ns/1ps
module driver_stage_model (
	input wire logic		driver_enable_out,
	input wire logic [1:0]	pwm_hiz,
	output logic [1:0]		stage_on
);
	// Enable input only listens, so it never loads the line during setup
	assign stage_on = {2{driver_enable_out}} & ~pwm_hiz;
endmodule

// >>> test/tb_top.sv
// Register, slew and current protection tests for the supervision block
`timescale 1ns/1ps
module tb_top;
	logic		clk_sys;
	logic		nrst;
	logic		enable_pin;
	logic		vboot;
	logic [15:0]	r_soft;
	logic [2:0]	hw_strap [2];
	logic [11:0]	sense_mv [2];
	logic [11:0]	mon_mv [2];
	logic [15:0]	reference [2];
	logic		svc;
	logic		sps;
	logic		auto_wr;
	logic		cmd_rail;
	logic		svc_fast;
	logic [7:0]	svc_code;
	logic [2:0]	ph_count;
	logic		proc_wr;
	logic		proc_rd;
	logic		proc_rail;
	logic [7:0]	proc_rdata;
	logic		mgmt_wr;
	logic		mgmt_rd;
	logic [7:0]	mgmt_rdata;
	logic [7:0]	bus_addr;
	logic [7:0]	bus_wdata;
	logic		driver_enable_out;
	logic		regulator_ready;
	logic		alert_n;
	logic [1:0]	warn;
	logic [1:0]	ocp_fault;
	logic [1:0]	pwm_hiz;
	logic [1:0]	stage_on;
	int		err_total = 0;
	int		checks_done = 0;
	int		cycles = 0;
	int		tab_kind [4] = '{1, 2, 1, 2};
	int		tab_rail [4] = '{0, 0, 1, 1};
	int		tab_ph [4] = '{1, 2, 2, 1};
	int		tab_lo [4] = '{780, 1100, 1260, 780};
	int		mon_tab [4] = '{600, 1350, 2100, 2500};
	logic [7:0]	rep_tab [4] = '{8'h00, 8'h7F, 8'hFF, 8'hFF};

	vr_current_protect_slew vr_current_protect_slew_inst (
		.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .enable_pin(enable_pin), .vboot_strap(vboot),
		.hw_phase_strap(hw_strap), .summed_current_sense(sense_mv), .current_monitor_pin(mon_mv),
		.set_voltage_command(svc), .svc_rail(cmd_rail), .svc_vid(svc_code), .svc_fast(svc_fast),
		.set_power_state_command(sps), .sps_rail(cmd_rail), .sps_phases(ph_count),
		.proc_wr(proc_wr), .proc_rd(proc_rd), .proc_addr(bus_addr), .proc_wdata(bus_wdata),
		.proc_rail(proc_rail), .proc_rdata(proc_rdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_addr(bus_addr), .mgmt_wdata(bus_wdata), .mgmt_rdata(mgmt_rdata), .auto_phase_wr(auto_wr),
		.auto_rail(cmd_rail), .auto_phases(ph_count), .driver_enable_out(driver_enable_out),
		.regulator_ready(regulator_ready), .alert_n(alert_n), .max_current_warning(warn),
		.ocp_fault(ocp_fault), .pwm_hiz(pwm_hiz), .reference(reference)
	);
	driver_stage_model driver_stage_model_inst (
		.driver_enable_out(driver_enable_out), .pwm_hiz(pwm_hiz), .stage_on(stage_on)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Verdict and end of run
	task automatic results();
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One register access; a read compares its data
	task automatic reg_op(input logic mgmt, input logic wr, input logic [7:0] addr, input logic [7:0] data);
		tick(1);
		mgmt_wr <= mgmt & wr;
		mgmt_rd <= mgmt & !wr;
		proc_wr <= !mgmt & wr;
		proc_rd <= !mgmt & !wr;
		bus_addr <= addr;
		bus_wdata <= data;
		tick(1);
		{mgmt_wr, mgmt_rd, proc_wr, proc_rd} <= 4'h0;
		tick(1);
		if (!wr)
			check("rdata", mgmt ? mgmt_rdata : proc_rdata, {8'h00, data});
	endtask
	// One-cycle command pulse: 0 voltage, 1 power state, 2 auto phase
	task automatic command(input int kind, input logic rail, input logic [7:0] val, input logic fast);
		tick(1);
		svc <= kind == 0;
		sps <= kind == 1;
		auto_wr <= kind == 2;
		cmd_rail <= rail;
		svc_code <= val;
		svc_fast <= fast;
		ph_count <= val[2:0];
		tick(1);
		{svc, sps, auto_wr} <= 3'h0;
	endtask
	// Retarget rail 0 upward and measure one reference step
	task automatic slew_chk(input logic fast, input int exp);
		logic [15:0] r0;
		command(0, 1'b0, 8'hFF, fast);
		tick(4);
		r0 = reference[0];
		tick(1);
		check("reference step", reference[0] - r0, 16'(exp));
	endtask
	task automatic wait_ready();
		for (int n = 0; n < 100 && regulator_ready !== 1'b1; n++)
			tick(1);
		check("regulator_ready", {15'h0000, regulator_ready}, 16'h0001);
	endtask
	// Wait for a trip, then look at the shutdown
	task automatic trip(input logic rail);
		for (int n = 0; n < 300 && ocp_fault[rail] !== 1'b1; n++)
			tick(1);
		tick(3);
		check("ocp_fault", {15'h0000, ocp_fault[rail]}, 16'h0001);
		check("pwm_hiz", {14'h0000, pwm_hiz}, 16'h0003);
		check("regulator_ready", {15'h0000, regulator_ready}, 16'h0000);
		check("stage_on", {14'h0000, stage_on}, 16'h0000);
	endtask
	task automatic reenable();
		tick(1);
		enable_pin <= 1'b0;
		tick(10);
		enable_pin <= 1'b1;
		wait_ready();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang limit
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			err_total++;
			results();
		end
	end

	// Main sequence
	initial
	begin
		nrst = 1'b0;
		enable_pin = 1'b0;
		hw_strap = '{3'h4, 3'h3};
		sense_mv = '{12'h000, 12'h000};
		mon_mv = '{12'h000, 12'h000};
		{svc, sps, auto_wr, cmd_rail, svc_fast, proc_rail} = 6'h00;
		{mgmt_wr, mgmt_rd, proc_wr, proc_rd} = 4'h0;
		svc_code = 8'h00;
		vboot = 1'b0;
		ph_count = 3'h0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		tick(4);
		nrst <= 1'b1;
		reg_op(1'b1, 1'b0, vr_protect_pkg::ADDR_FAST_SLEW, vr_protect_pkg::FAST_SLEW_RESET);
		enable_pin <= 1'b1;
		wait_ready();
		check("driver_enable_out", {15'h0000, driver_enable_out}, 16'h0001);
		slew_chk(1'b1, 24);
		slew_chk(1'b0, 12);
		reg_op(1'b1, 1'b1, vr_protect_pkg::ADDR_SLOW_SLEW, 8'h05);
		reg_op(1'b0, 1'b0, vr_protect_pkg::ADDR_SLOW_SLEW, 8'h00);
		reg_op(1'b0, 1'b0, 8'h33, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			reg_op(1'b1, 1'b1, vr_protect_pkg::ADDR_FAST_SLEW, 8'(c * 17));
			reg_op(1'b1, 1'b0, vr_protect_pkg::ADDR_FAST_SLEW, 8'(c * 17));
			slew_chk(1'b1, 6 + 9 * c);
		end
		reg_op(1'b0, 1'b1, vr_protect_pkg::ADDR_SLOW_SLEW, 8'h03);
		slew_chk(1'b0, 33);
		// Report conversion on both rails
		for (int i = 0; i < 4; i++)
		begin
			mon_mv[i % 2] <= 12'(mon_tab[i]);
			proc_rail <= 1'(i % 2);
			tick(6);
			reg_op(1'b0, 1'b0, vr_protect_pkg::ADDR_CURRENT_REPORT, rep_tab[i]);
			check("warning", {14'h0000, warn}, 16'h0000);
		end
		// Warning, restart of the delay, trip and latch
		sense_mv[0] <= 12'h76C;
		tick(150);
		check("warning", {14'h0000, warn}, 16'h0001);
		check("alert_n", {15'h0000, alert_n}, 16'h0000);
		check("ocp_fault", {14'h0000, ocp_fault}, 16'h0000);
		sense_mv[0] <= 12'h7D0;
		tick(60);
		sense_mv[0] <= 12'h1F4;
		tick(5);
		sense_mv[0] <= 12'h7D0;
		tick(60);
		check("ocp_fault", {14'h0000, ocp_fault}, 16'h0000);
		trip(1'b0);
		sense_mv[0] <= 12'h000;
		reg_op(1'b1, 1'b1, vr_protect_pkg::ADDR_FAST_SLEW, 8'h22);
		tick(200);
		check("ocp_fault", {15'h0000, ocp_fault[0]}, 16'h0001);
		reenable();
		check("ocp_fault", {14'h0000, ocp_fault}, 16'h0000);
		// Limit scaled by phase count
		for (int i = 0; i < 4; i++)
		begin
			command(tab_kind[i], tab_rail[i] == 1, 8'(tab_ph[i]), 1'b0);
			sense_mv[tab_rail[i]] <= 12'(tab_lo[i]);
			tick(150);
			check("ocp_fault", {14'h0000, ocp_fault}, 16'h0000);
			sense_mv[tab_rail[i]] <= 12'(tab_lo[i] + 70);
			trip(tab_rail[i] == 1);
			sense_mv[tab_rail[i]] <= 12'h000;
			reenable();
		end
		// Non-zero boot after a second reset: soft start at the slow rate
		vboot <= 1'b1;
		nrst <= 1'b0;
		tick(4);
		nrst <= 1'b1;
		tick(8);
		r_soft = reference[1];
		tick(1);
		check("soft step", reference[1] - r_soft, 16'h000C);
		check("regulator_ready", {15'h0000, regulator_ready}, 16'h0000);
		results();
	end
endmodule
